// >>> verilog/triggered_pulse_timer.sv
/*
  16-bit triggered pulse timer channel: triggered pwm mode and one-shot
  mode, shadowed period/duty compare, count snapshot, two match strobes.
  assumes a single 50 MHz clock, synchronous active-high reset, a plain
  register port driven from the same clock and an asynchronous trigger pin.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
// Behaviour
// R1 - pwm period is period+1 count cycles, active width equals duty count.
// R2 - snapshot register read returns the live 16-bit counter value.
// R3 - only a duty register write arms the shadow transfer.
// R4 - armed values copy into shadows when counter clears, then compare.
// R5 - software writes period first, duty last; rewrite duty for period-only.
// R6 - no further compare writes after duty write until period match.
// R7 - duty zero gives inactive output; duty match still fires each period.
// R8 - duty equal period+1 gives constant active output; impossible at FFFFH.
// R9 - trigger after duty match clears counter, asserts pulse, keeps counting.
// R10 - trigger before duty match suppresses duty strobe, pulse stays active.
// R11 - trigger after period match clears counter, counting continues.
// R12 - trigger before period match suppresses period strobe, asserts pulse.
// R13 - pwm duty strobe fires on the count that equals duty shadow.
// R14 - mode 011 with run bit set idles waiting for a trigger.
// R15 - one-shot trigger clears FFFFH to 0000H, counts, makes one pulse.
// R16 - one-shot end loads FFFFH and halts; triggers during pulse ignored.
// R17 - one-shot delay is duty cycles, width is period-duty+1 cycles.
// R18 - one-shot secondary output active while counting, inactive waiting.
// R19 - trigger is a valid pin edge or soft trigger bit written one.
// R20 - one-shot period strobe on count after match, duty strobe on match.
// R21 - mode 010 selects triggered pwm started by a trigger from FFFFH.
// R22 - pwm retrigger clears counter, inverts secondary, drives pulse high.
// R23 - pwm pulse rises on counter clear, falls on duty shadow match.
module triggered_pulse_timer
  import tpt_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic trig_in,
  output logic pulse_output_out,
  output logic secondary_output_out,
  output logic period_match_irq_out,
  output logic duty_match_irq_out
);

  typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_COUNT} run_state_e;

  // control and compare registers
  logic run_q;
  logic [2:0] mode_q;
  logic [1:0] edge_q;
  logic [3:0] div_q;
  logic [DATA_W-1:0] period_compare_reg_q;
  logic [DATA_W-1:0] duty_compare_reg_q;
  logic [DATA_W-1:0] per_sh_q;
  logic [DATA_W-1:0] duty_sh_q;
  logic armed_q;
  logic soft_trig_q;
  logic [DATA_W-1:0] rdata_q;

  // counting state
  run_state_e state_q, state_d;
  logic [DATA_W-1:0] cnt_q, cnt_d;
  logic pulse_q, pulse_d;
  logic sec_q, sec_d;
  logic per_irq_q, per_irq_d;
  logic duty_irq_q, duty_irq_d;

  // prescaler and trigger capture
  logic [DATA_W-1:0] div_cnt_q;
  logic [2:0] trig_sync_q;
  logic trig_pend_q;

  // register address decode
  wire logic wr_ctrl = wr_in && (addr_in == CTRL_OFS);
  wire logic wr_per = wr_in && (addr_in == PERIOD_OFS);
  wire logic wr_duty = wr_in && (addr_in == DUTY_OFS);

  // mode decode
  wire logic is_pwm = (mode_q == MODE_TRIG_PWM);
  wire logic is_os = (mode_q == MODE_ONE_SHOT);
  wire logic mode_ok = run_q && (is_pwm || is_os);

  function automatic logic [DATA_W-1:0] ctrl_word(
    input logic run,
    input logic [2:0] mode,
    input logic [1:0] edge_sel,
    input logic [3:0] div
  );
    logic [DATA_W-1:0] w;
    w = REG_RST;
    w[RUN_BIT] = run;
    w[MODE_MSB:MODE_LSB] = mode;
    w[EDGE_MSB:EDGE_LSB] = edge_sel;
    w[DIV_MSB:DIV_LSB] = div;
    return w;
  endfunction

  // count clock enable: one pulse every 2^div master clocks
  wire logic [DATA_W-1:0] div_mask = (CNT_ONE << div_q) - CNT_ONE;
  wire logic tick = ((div_cnt_q & div_mask) == div_mask);

  // trigger pin: two flops, then edge detect on the settled copies
  wire logic rise = trig_sync_q[1] && !trig_sync_q[2];
  wire logic fall = !trig_sync_q[1] && trig_sync_q[2];
  wire logic pin_edge = ((edge_q == EDGE_RISE) && rise) ||
                        ((edge_q == EDGE_FALL) && fall) ||
                        ((edge_q == EDGE_BOTH) && (rise || fall));
  // an edge between count ticks is held so it lands on the next tick
  wire logic trig_any = pin_edge || soft_trig_q || trig_pend_q; // see R19
  wire logic trig = trig_any && tick && mode_ok;

  // compare events on the present count
  wire logic per_hit = (cnt_q == per_sh_q);
  wire logic clear_cnt = (state_q == ST_COUNT) && tick && per_hit;
  wire logic os_end = is_os && clear_cnt;
  // shadows follow the registers while idle, and on an armed clear
  wire logic load_sh = (state_q != ST_COUNT) ||
                       (armed_q && (clear_cnt || (trig && is_pwm)));

  // next state of counter and outputs
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pulse_d = pulse_q;
    sec_d = sec_q;
    per_irq_d = 1'b0;
    duty_irq_d = 1'b0;
    if (!mode_ok) begin
      state_d = ST_STOP;
      cnt_d = CNT_IDLE;
      pulse_d = 1'b0;
      sec_d = 1'b0;
    end else if (state_q == ST_STOP) begin
      state_d = ST_WAIT; // see R14
      cnt_d = CNT_IDLE;
    end else if (state_q == ST_WAIT) begin
      if (trig) begin
        state_d = ST_COUNT; // see R15 R21
        cnt_d = CNT_ZERO;
        if (is_pwm) begin
          pulse_d = (duty_sh_q != CNT_ZERO);
          duty_irq_d = (duty_sh_q == CNT_ZERO);
          sec_d = !sec_q; // see R22
        end else begin
          pulse_d = (duty_sh_q == CNT_ZERO);
          duty_irq_d = (duty_sh_q == CNT_ZERO);
          sec_d = 1'b1; // see R18
        end
      end
    end else if (tick) begin
      if (is_pwm && trig) begin
        // a retrigger wins over both matches of this count
        cnt_d = CNT_ZERO; // see R9 R10 R11 R12 R22
        sec_d = !sec_q;
        pulse_d = (duty_sh_q != CNT_ZERO) || pulse_q;
      end else if (os_end) begin
        // pulse done: park at FFFFH and wait again
        state_d = ST_WAIT; // see R16
        cnt_d = CNT_IDLE;
        pulse_d = 1'b0;
        sec_d = 1'b0; // see R18
        per_irq_d = 1'b1; // see R20
      end else if (per_hit) begin
        cnt_d = CNT_ZERO; // see R1 R23
        per_irq_d = 1'b1;
        pulse_d = 1'b1; // see R8
        if (duty_sh_q == CNT_ZERO) begin
          pulse_d = 1'b0; // see R7
          duty_irq_d = 1'b1;
        end
      end else begin
        // triggers during a one-shot pulse are simply not looked at
        cnt_d = cnt_q + CNT_ONE; // see R16
        if (cnt_d == duty_sh_q) begin
          duty_irq_d = 1'b1; // see R13 R20
          pulse_d = is_os; // see R17 R23
        end
      end
    end
  end

  // when a retrigger reloads the shadows the old duty shadow still gates the pulse;
  // the shadow loaded here is only used from the following count on
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q <= ST_STOP;
      cnt_q <= CNT_IDLE;
      pulse_q <= 1'b0;
      sec_q <= 1'b0;
      per_irq_q <= 1'b0;
      duty_irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
      sec_q <= sec_d;
      per_irq_q <= per_irq_d;
      duty_irq_q <= duty_irq_d;
    end
  end

  // prescaler runs only while counting is enabled
  always_ff @(posedge mclk_in) begin
    if (srst_in || !run_q) begin
      div_cnt_q <= CNT_ZERO;
    end else begin
      div_cnt_q <= div_cnt_q + CNT_ONE;
    end
  end

  // trigger synchroniser and pending latch; a tick clears the latch even when a new edge arrives with it
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      trig_sync_q <= 3'h0;
      trig_pend_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], trig_in};
      trig_pend_q <= (pin_edge || soft_trig_q || trig_pend_q) && !tick
                     && run_q;
    end
  end

  // control and compare registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      run_q <= 1'b0;
      mode_q <= 3'h0;
      edge_q <= EDGE_NONE;
      div_q <= DIV_ZERO;
      soft_trig_q <= 1'b0;
      period_compare_reg_q <= REG_RST;
      duty_compare_reg_q <= REG_RST;
    end else begin
      soft_trig_q <= wr_ctrl && wdata_in[SOFT_TRIG_BIT]; // see R19
      if (wr_ctrl) begin
        run_q <= wdata_in[RUN_BIT];
        mode_q <= wdata_in[MODE_MSB:MODE_LSB];
        edge_q <= wdata_in[EDGE_MSB:EDGE_LSB];
        div_q <= wdata_in[DIV_MSB:DIV_LSB];
      end
      if (wr_per) begin
        period_compare_reg_q <= wdata_in;
      end
      if (wr_duty) begin
        duty_compare_reg_q <= wdata_in;
      end
    end
  end

  // shadow buffers and the arm flag; a duty write in the load cycle
  // re-arms so the newest values are not lost
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      per_sh_q <= REG_RST;
      duty_sh_q <= REG_RST;
      armed_q <= 1'b0;
    end else begin
      if (load_sh) begin
        per_sh_q <= period_compare_reg_q; // see R4
        duty_sh_q <= duty_compare_reg_q;
      end
      armed_q <= wr_duty || (armed_q && !load_sh); // see R3
    end
  end

  // read data, valid the cycle after the strobe only
  wire logic [DATA_W-1:0] status_word = {12'h000, sec_q, pulse_q, armed_q,
                                         (state_q == ST_COUNT)};
  wire logic [DATA_W-1:0] rd_mux =
    (addr_in == CTRL_OFS) ? ctrl_word(run_q, mode_q, edge_q, div_q) :
    (addr_in == PERIOD_OFS) ? period_compare_reg_q :
    (addr_in == DUTY_OFS) ? duty_compare_reg_q :
    (addr_in == COUNT_OFS) ? cnt_q : // see R2
    (addr_in == STATUS_OFS) ? status_word : REG_RST;

  always_ff @(posedge mclk_in) begin
    if (srst_in || !rd_in) begin
      rdata_q <= REG_RST;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  assign rdata_out = rdata_q;
  assign pulse_output_out = pulse_q;
  assign secondary_output_out = sec_q;
  assign period_match_irq_out = per_irq_q;
  assign duty_match_irq_out = duty_irq_q;

  // checks on the timer behaviour
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence s_os_last;
    (state_q == ST_COUNT) && is_os && run_q && tick && per_hit;
  endsequence

  sequence s_os_parked;
    (cnt_q == CNT_IDLE) && (state_q == ST_WAIT) && !pulse_q
      && per_irq_q;
  endsequence

  a_snapshot_read: assert property ( // see R2
    rd_in && (addr_in == COUNT_OFS) |=> rdata_out == $past(cnt_q))
    else $error("count snapshot read mismatch");

  a_period_wrap: assert property ( // see R1
    (state_q == ST_COUNT) && is_pwm && run_q && tick && per_hit && !trig
    |=> (cnt_q == CNT_ZERO) && per_irq_q)
    else $error("period match did not clear counter");

  a_retrig_clear: assert property ( // see R22
    (state_q == ST_COUNT) && is_pwm && run_q && trig
    |=> (cnt_q == CNT_ZERO) && (sec_q != $past(sec_q)))
    else $error("retrigger did not clear and toggle");

  a_trig_suppress: assert property ( // see R10
    (state_q == ST_COUNT) && is_pwm && run_q && trig
    |=> !per_irq_q && !duty_irq_q && (pulse_q || $past(duty_sh_q) == CNT_ZERO))
    else $error("match strobe not suppressed by trigger");

  a_duty_fall: assert property ( // see R13
    duty_irq_q && is_pwm && run_q |-> !pulse_q)
    else $error("pwm duty strobe not aligned with pulse fall");

  a_os_end: assert property ( // see R16
    s_os_last |=> s_os_parked)
    else $error("one-shot did not park at idle");

  a_os_ignore: assert property ( // see R16
    (state_q == ST_COUNT) && is_os && run_q && tick && !per_hit
    |=> cnt_q == $past(cnt_q) + CNT_ONE)
    else $error("one-shot count disturbed");

  a_arm_duty_only: assert property ( // see R3
    wr_per && !wr_duty && !armed_q |=> !armed_q)
    else $error("period write armed the transfer");

  a_shadow_load: assert property ( // see R4
    armed_q && clear_cnt && is_pwm |=>
      per_sh_q == $past(period_compare_reg_q))
    else $error("shadow not loaded at clear");

  a_sec_oneshot: assert property ( // see R18
    is_os && run_q && $past(is_os && run_q) |->
      secondary_output_out == (state_q == ST_COUNT))
    else $error("secondary output does not follow counting");

endmodule

// >>> common/tpt_pkg.sv
/*
  constants shared by the triggered pulse timer: register offsets, control
  field layout, mode codes, counter limits.
  assumes a 16-bit register port with byte offsets on 8 address bits.
*/
package tpt_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PERIOD_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] DUTY_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;

  // control register fields
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned MODE_LSB = 1;
  localparam int unsigned MODE_MSB = 3;
  localparam int unsigned SOFT_TRIG_BIT = 4;
  localparam int unsigned EDGE_LSB = 5;
  localparam int unsigned EDGE_MSB = 6;
  localparam int unsigned DIV_LSB = 8;
  localparam int unsigned DIV_MSB = 11;

  // status register fields
  localparam int unsigned ST_RUNNING_BIT = 0;
  localparam int unsigned ST_ARMED_BIT = 1;
  localparam int unsigned ST_PULSE_BIT = 2;
  localparam int unsigned ST_SEC_BIT = 3;

  // mode select codes
  localparam logic [2:0] MODE_TRIG_PWM = 3'h2;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h3;

  // trigger edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // counter limits and reset values
  localparam logic [DATA_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] CNT_IDLE = 16'hFFFF;
  localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
  localparam logic [3:0] DIV_ZERO = 4'h0;

endpackage

// >>> bench/trig_source.sv
/*
  partner model: the external trigger source wired to the timer's trigger
  pin. assumes the timer samples the pin on the same 50 MHz clock and
  detects rising edges after a two-flop synchroniser.
*/
module trig_source (
  input wire logic mclk_in,
  output logic trig_out
);
  timeunit 1ns;
  timeprecision 1ps;
  parameter int LAG = 1;
  parameter int HOLD = 4;

  // pin idles low; it is a driven line, never released
  initial trig_out = 1'b0;

  // one clean edge, held past the synchroniser depth so it is not lost
  task automatic fire();
    repeat (LAG) @(posedge mclk_in);
    trig_out <= 1'b1;
    repeat (HOLD) @(posedge mclk_in);
    trig_out <= 1'b0;
  endtask
endmodule

// >>> bench/triggered_pulse_timer_tb.sv
/*
  self-checking bench for the triggered pulse timer: register tasks, an
  edge timestamp monitor and directed pwm and one-shot sequences.
  assumes the register port answers reads one cycle later, never stalls.
*/
module triggered_pulse_timer_tb;
  import tpt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = 8'h00;
  logic [DATA_W-1:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic trig_in;
  logic pulse, sec, per_irq, duty_irq, pul_q = 1'b0, sec_q = 1'b0;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0, t_pr, t_pf, t_sr, t_sf, t_d, t_p0, t_p1, h;
  logic [15:0] v, w;

  // 50 MHz clock
  always #10 mclk_in = ~mclk_in;

  triggered_pulse_timer i_dut (.mclk_in(mclk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .trig_in(trig_in), .pulse_output_out(pulse),
    .secondary_output_out(sec), .period_match_irq_out(per_irq),
    .duty_match_irq_out(duty_irq));
  trig_source i_src (.mclk_in(mclk_in), .trig_out(trig_in));

  // timestamps of output edges; sampled pre-update, so differences hold
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (pulse && !pul_q) t_pr <= cyc;
    if (!pulse && pul_q) t_pf <= cyc;
    if (sec && !sec_q) t_sr <= cyc;
    if (!sec && sec_q) t_sf <= cyc;
    if (duty_irq) t_d <= cyc;
    if (per_irq) begin
      t_p1 <= t_p0;
      t_p0 <= cyc;
    end
    pul_q <= pulse;
    sec_q <= sec;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  // bounded wait: 0 period strobe, 1 pulse high, 2 secondary low;
  // one more edge lets the monitor record the hit before checks
  task automatic wait_sig(input int sel, input int bound);
    for (int i = 0; i < bound; i++) begin
      @(posedge mclk_in);
      #1;
      if ((sel == 0 && per_irq === 1'b1) || (sel == 1 && pulse === 1'b1)
          || (sel == 2 && sec === 1'b0)) begin
        @(posedge mclk_in);
        #1;
        return;
      end
    end
    fail_count++;
    $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    close_out();
  endtask

  task automatic count_high(input int n);
    h = 0;
    repeat (n) begin
      @(posedge mclk_in);
      #1;
      if (pulse === 1'b1) h++;
    end
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge mclk_in);
    srst_in <= 1'b0;
    #1;
    chk({pulse, sec, per_irq, duty_irq}, 16'h0000);
    rd(COUNT_OFS, v); chk(v, CNT_IDLE);
    rd(8'h14, v); chk(v, 16'h0000);
    // triggered pwm, period 3 duty 2, started from the pin
    wr(PERIOD_OFS, 16'h0003);
    wr(DUTY_OFS, 16'h0002);
    wr(CTRL_OFS, 16'h0025);
    rd(COUNT_OFS, v); chk(v, CNT_IDLE);
    chk({15'h0000, pulse}, 16'h0000);
    i_src.fire();
    wait_sig(0, 40);
    chk({15'h0000, sec}, 16'h0001);
    wait_sig(0, 20);
    chk(16'(t_p0 - t_p1), 16'h0004);
    // active width is the period less the inactive gap before the last rise
    chk(16'(t_p0 - t_p1 - (t_pr - t_pf)), 16'h0002);
    chk(16'(t_d), 16'(t_pf));
    chk(16'(t_pr), 16'(t_p0));
    // a period write alone changes nothing; the duty write arms it
    wr(PERIOD_OFS, 16'h0005);
    wait_sig(0, 20);
    wait_sig(0, 20);
    chk(16'(t_p0 - t_p1), 16'h0004);
    wr(DUTY_OFS, 16'h0002);
    wait_sig(0, 20);
    wait_sig(0, 20);
    chk(16'(t_p0 - t_p1), 16'h0006);
    // back-to-back snapshot reads, two cycles apart
    rd(COUNT_OFS, v);
    rd(COUNT_OFS, w);
    chk(16'((int'(w) + 6 - int'(v)) % 6), 16'h0002);
    // retrigger in mid-count restarts from zero
    i_src.fire();
    wait_sig(2, 20);
    // pulse rises on the same edge as the secondary output inverts
    chk(16'(t_pr), 16'(t_sf));
    // counter restarted at that edge and has counted once per cycle since
    rd(COUNT_OFS, v); chk(v, 16'(cyc - 1 - t_sf));
    // 0% and 100% duty
    wait_sig(0, 20);
    wr(DUTY_OFS, 16'h0000);
    wait_sig(0, 20);
    wait_sig(0, 20);
    count_high(12); chk(16'(h), 16'h0000);
    wr(DUTY_OFS, 16'h0006);
    wait_sig(0, 20);
    wait_sig(0, 20);
    count_high(12); chk(16'(h), 16'h000C);
    // one-shot, period 5 duty 2, soft trigger
    wr(CTRL_OFS, 16'h0000);
    wr(PERIOD_OFS, 16'h0005);
    wr(DUTY_OFS, 16'h0002);
    wr(CTRL_OFS, 16'h0027);
    rd(COUNT_OFS, v); chk(v, CNT_IDLE);
    chk({15'h0000, sec}, 16'h0000);
    wr(CTRL_OFS, 16'h0037);
    wait_sig(0, 40);
    chk(16'(t_pr - t_sr), 16'h0002);
    chk(16'(t_pf - t_pr), 16'h0004);
    chk(16'(t_d), 16'(t_pr));
    chk(16'(t_p0), 16'(t_pf));
    chk(16'(t_sf - t_sr), 16'h0006);
    rd(COUNT_OFS, v); chk(v, CNT_IDLE);
    // soft trigger bit reads back as zero; idle status is all clear
    rd(CTRL_OFS, v); chk(v, 16'h0027);
    rd(STATUS_OFS, v); chk(v, 16'h0000);
    // a second shot with a trigger landing in mid-pulse
    wr(CTRL_OFS, 16'h0037);
    wait_sig(1, 40);
    wr(CTRL_OFS, 16'h0037);
    wait_sig(0, 20);
    chk(16'(t_pf - t_pr), 16'h0004);
    repeat (12) @(posedge mclk_in);
    rd(COUNT_OFS, v); chk(v, CNT_IDLE);
    chk({15'h0000, pulse}, 16'h0000);
    close_out();
  end
endmodule
